// File: verilog/mcw_params.svh
// Purpose: Constants for the multiple coil write and error reply block.
// Assumes: Included by the package user; byte addresses on a 32-bit Avalon-MM bus.
// Notes: Definitions only.
`ifndef MCW_PARAMS_SVH
`define MCW_PARAMS_SVH

`define MCW_REG_STATION 5'h00
`define MCW_REG_BIT_CYCLES 5'h04
`define MCW_REG_REFUSE 5'h08
`define MCW_REG_RUN_CMD 5'h0c
`define MCW_REG_COMM_ERR 5'h10
`define MCW_REG_STATUS 5'h14

`define MCW_STATION_RESET 8'h01
`define MCW_BIT_CYCLES_RESET 16'h32dd
`define MCW_GAP_BITS 6'h21
`define MCW_BCAST_ADDR 8'h00
`define MCW_MIN_FRAME 4'h4
`define MCW_BUF_BYTES 4'hb

`define MCW_CRC_INIT 16'hffff
`define MCW_CRC_POLY 16'ha001

`define MCW_FC_READ_COILS 8'h01
`define MCW_FC_READ_REGS 8'h03
`define MCW_FC_WRITE_COIL 8'h05
`define MCW_FC_WRITE_REG 8'h06
`define MCW_FC_DIAG 8'h08
`define MCW_FC_WRITE_COILS 8'h0f
`define MCW_FC_WRITE_REGS 8'h10
`define MCW_EXC_FLAG 8'h80

`define MCW_COIL_LIMIT 16'h0010
`define MCW_COUNT_MAX 16'h0010
`define MCW_COUNT_ONE_BYTE 16'h0008
`define MCW_BC_MAX 8'h02
`define MCW_RUN_RESERVED 16'h0e00

`define MCW_SUB_NONE 8'h00
`define MCW_SUB_FC 8'h01
`define MCW_SUB_ADDR 8'h02
`define MCW_SUB_DATA 8'h03
`define MCW_SUB_NAK 8'h07

`define MCW_LEN_ERR 3'h3
`define MCW_LEN_ECHO 3'h6

`define MCW_REF_PARAM 0
`define MCW_REF_COUNT 1
`define MCW_REF_DIAG 2
`define MCW_REF_RANGE 3
`define MCW_REF_NAK 4
`define MCW_REF_NAK_FIRST 5

`endif

// File: verilog/mcw_pkg.sv
// Purpose: Types for the multiple coil write and error reply block.
// Assumes: Constants come from mcw_params.svh.
// Notes: States are Gray coded along idle, evaluate, send.
package mcw_pkg;

	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b00,
		ST_EVAL = 2'b01,
		ST_SEND = 2'b11
	} mcw_state_t;

endpackage

// File: verilog/mcw_multi_coil_write.sv
// Purpose: Serial query handling for write multiple coils and exception replies.
// Assumes: rx/tx byte streams come from a UART on the same clock; 125 MHz clock.
// Notes: Frames end after a 33 bit silence; only frames with a good check are used.
// Operation
// - Broadcast station zero multiple coil write executes but never sends any reply.
// - Coils 1-16 map onto run command word bits 0 to 15.
// - Coil address is number minus one; addresses 16 and above give subcode 2.
// - Byte count of zero or three and more gives subcode 3.
// - Coil count zero or above sixteen gives subcode 2.
// - Start address plus count running past the coil range is accepted.
// - Count nine or more with byte count one or less gives subcode 3.
// - Count eight or less with byte count two is accepted.
// - Data bits taken LSB first in ascending coil order; extra bits ignored.
// - Reserved coil positions always read back as zero.
// - Good write is answered by echoing start address and coil count.
// - Bad query is not executed; reply is station, exception, subcode, check.
// - Error reply carries the query's own station address.
// - Exception byte is function plus 80 hex, unchanged when above 80 hex.
// - Unsupported function gives subcode 1 with the highest priority.
// - Bad parameter code, count or diagnostic sub-function gives subcode 2.
// - Unused later items in a multi-item transfer raise no error.
// - Start code plus item count past the range raises no error.
// - Out of range write data gives subcode 3; order against 7 selectable.
// - Missing write right or forbidden write gives subcode 7.
// - Every sent error reply stores its subcode in the comm error code.
// - A 33 bit silence ends a frame; a broken partial frame is discarded.
`timescale 1ns/100ps
`default_nettype none
`include "mcw_params.svh"

module mcw_multi_coil_write
	import mcw_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [7:0] rx_data,
	input wire logic rx_valid,
	output logic [7:0] tx_data,
	output logic tx_valid,
	input wire logic tx_ready,
	output logic [15:0] run_command_word,
	output logic [7:0] comm_error_code
);

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);

	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++)
			r = r[0] ? ((r >> 1) ^ `MCW_CRC_POLY) : (r >> 1);
		return r;
	endfunction

	function automatic logic fc_supported(input logic [7:0] f);
		return f == `MCW_FC_READ_COILS || f == `MCW_FC_READ_REGS ||
			f == `MCW_FC_WRITE_COIL || f == `MCW_FC_WRITE_REG ||
			f == `MCW_FC_DIAG || f == `MCW_FC_WRITE_COILS || f == `MCW_FC_WRITE_REGS;
	endfunction

	logic [7:0] station;
	logic [15:0] bit_cycles;
	logic [5:0] refuse;
	logic last_error;
	logic [15:0] div_cnt;
	logic bit_tick;
	logic [5:0] gap_bits;
	logic armed;
	logic [3:0] rx_count;
	logic [15:0] rx_crc;
	logic [7:0] rxb [0:10];
	mcw_state_t state;
	logic [7:0] resp [0:5];
	logic [2:0] resp_len;
	logic [3:0] tx_idx;
	logic [15:0] tx_crc;

	// Bus slave: every access waits exactly one cycle, so one request is
	// answered per two clocks and back-to-back requests need no extra state.
	logic bus_take;
	assign bus_take = (avs_read || avs_write) && avs_waitrequest;

	always_ff @(posedge clock)
	begin
		if (sys_rst)
			avs_waitrequest <= 1'b1;
		else
			avs_waitrequest <= !bus_take;
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
			avs_readdata <= 32'h0000_0000;
		else if (avs_read && avs_waitrequest)
		begin
			unique case (avs_address)
				`MCW_REG_STATION: avs_readdata <= {24'h00_0000, station};
				`MCW_REG_BIT_CYCLES: avs_readdata <= {16'h0000, bit_cycles};
				`MCW_REG_REFUSE: avs_readdata <= {26'h000_0000, refuse};
				`MCW_REG_RUN_CMD: avs_readdata <= {16'h0000, run_command_word};
				`MCW_REG_COMM_ERR: avs_readdata <= {24'h00_0000, comm_error_code};
				`MCW_REG_STATUS: avs_readdata <= {30'h0000_0000, last_error, state != ST_IDLE};
				default: avs_readdata <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			station <= `MCW_STATION_RESET;
			bit_cycles <= `MCW_BIT_CYCLES_RESET;
			refuse <= 6'h00;
		end
		else if (avs_write && !avs_waitrequest)
		begin
			if (avs_address == `MCW_REG_STATION)
				station <= avs_writedata[7:0];
			if (avs_address == `MCW_REG_BIT_CYCLES)
				bit_cycles <= avs_writedata[15:0];
			if (avs_address == `MCW_REG_REFUSE)
				refuse <= avs_writedata[5:0];
		end
	end

	// Bit time enable, restarted by every received byte so silence is
	// measured from the end of the last character.
	always_ff @(posedge clock)
	begin
		if (sys_rst || rx_valid)
		begin
			div_cnt <= 16'h0000;
			bit_tick <= 1'b0;
		end
		else if (16'(div_cnt + 16'h0001) >= bit_cycles)
		begin
			div_cnt <= 16'h0000;
			bit_tick <= 1'b1;
		end
		else
		begin
			div_cnt <= 16'(div_cnt + 16'h0001);
			bit_tick <= 1'b0;
		end
	end

	logic gap_end;
	logic frame_go;
	assign gap_end = bit_tick && gap_bits == 6'(`MCW_GAP_BITS - 6'h01);
	// A gap inside a frame cuts it short, so its check fails and it is dropped.
	assign frame_go = gap_end && armed && rx_count >= `MCW_MIN_FRAME && rx_crc == 16'h0000 &&
		(rxb[0] == station || rxb[0] == `MCW_BCAST_ADDR) && state == ST_IDLE;

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			gap_bits <= 6'h00;
			armed <= 1'b0;
			rx_count <= 4'h0;
			rx_crc <= `MCW_CRC_INIT;
		end
		else if (rx_valid)
		begin
			gap_bits <= 6'h00;
			if (armed && state == ST_IDLE)
			begin
				if (rx_count < `MCW_BUF_BYTES)
					rxb[rx_count] <= rx_data;
				if (rx_count != 4'hf)
					rx_count <= 4'(rx_count + 4'h1);
				rx_crc <= crc_byte(rx_crc, rx_data);
			end
		end
		else if (bit_tick && gap_bits != `MCW_GAP_BITS)
		begin
			gap_bits <= 6'(gap_bits + 6'h01);
			if (gap_end)
			begin
				armed <= 1'b1;
				rx_count <= 4'h0;
				rx_crc <= `MCW_CRC_INIT;
			end
		end
	end

	logic [7:0] q_fc;
	logic [15:0] q_addr;
	logic [15:0] q_cnt;
	logic [7:0] q_bc;
	logic [15:0] q_data;
	logic [7:0] next_sub;
	logic q_write;
	logic q_reply;
	assign q_fc = rxb[1];
	assign q_addr = {rxb[2], rxb[3]};
	assign q_cnt = {rxb[4], rxb[5]};
	assign q_bc = rxb[6];
	// With one data byte, buffer slot 8 holds the check, not coil data.
	assign q_data = (q_bc >= `MCW_BC_MAX) ? {rxb[8], rxb[7]} : {8'h00, rxb[7]};

	// Refusal bits judge the first item only, so later items and an overrun raise no error.
	always_comb
	begin
		next_sub = `MCW_SUB_NONE;
		if (!fc_supported(q_fc))
			next_sub = `MCW_SUB_FC;
		else if ((q_fc == `MCW_FC_WRITE_COILS && (q_addr >= `MCW_COIL_LIMIT ||
			q_cnt == 16'h0000 || q_cnt > `MCW_COUNT_MAX)) ||
			refuse[`MCW_REF_PARAM] || refuse[`MCW_REF_COUNT] || refuse[`MCW_REF_DIAG])
			next_sub = `MCW_SUB_ADDR;
		else if (q_fc == `MCW_FC_WRITE_COILS && (q_bc == 8'h00 || q_bc > `MCW_BC_MAX ||
			(q_cnt > `MCW_COUNT_ONE_BYTE && q_bc < `MCW_BC_MAX)))
			next_sub = `MCW_SUB_DATA;
		else if (refuse[`MCW_REF_NAK] && refuse[`MCW_REF_NAK_FIRST])
			next_sub = `MCW_SUB_NAK;
		else if (refuse[`MCW_REF_RANGE])
			next_sub = `MCW_SUB_DATA;
		else if (refuse[`MCW_REF_NAK])
			next_sub = `MCW_SUB_NAK;
	end

	// An end past coil 16 is not an error; those coils simply do not exist.
	assign q_write = state == ST_EVAL && q_fc == `MCW_FC_WRITE_COILS &&
		next_sub == `MCW_SUB_NONE;
	// Other supported functions without an error belong to another handler.
	assign q_reply = rxb[0] != `MCW_BCAST_ADDR &&
		(next_sub != `MCW_SUB_NONE || q_fc == `MCW_FC_WRITE_COILS);

	logic [15:0] next_run;
	for (genvar g = 0; g < 16; g++)
	begin : g_coil
		logic [4:0] off;
		logic hit;
		assign off = 5'(5'(g) - q_addr[4:0]);
		assign hit = q_write && 16'(g) >= q_addr && 16'({11'h000, off}) < q_cnt;
		assign next_run[g] = hit ? q_data[off[3:0]] : run_command_word[g];
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
			run_command_word <= 16'h0000;
		else
			run_command_word <= next_run & ~`MCW_RUN_RESERVED;
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			comm_error_code <= `MCW_SUB_NONE;
			last_error <= 1'b0;
			resp_len <= `MCW_LEN_ECHO;
		end
		else if (state == ST_EVAL && q_reply)
		begin
			resp[0] <= rxb[0];
			if (next_sub != `MCW_SUB_NONE)
			begin
				resp[1] <= (q_fc > `MCW_EXC_FLAG) ? q_fc : 8'(q_fc + `MCW_EXC_FLAG);
				resp[2] <= next_sub;
				resp_len <= `MCW_LEN_ERR;
				comm_error_code <= next_sub;
				last_error <= 1'b1;
			end
			else
			begin
				for (int i = 1; i < 6; i++)
					resp[i] <= rxb[i];
				resp_len <= `MCW_LEN_ECHO;
				last_error <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			state <= ST_IDLE;
			tx_valid <= 1'b0;
			tx_data <= 8'h00;
			tx_idx <= 4'h0;
			tx_crc <= `MCW_CRC_INIT;
		end
		else
		begin
			unique case (state)
				ST_IDLE:
				begin
					if (frame_go)
						state <= ST_EVAL;
				end
				ST_EVAL:
				begin
					if (q_reply)
					begin
						state <= ST_SEND;
						tx_valid <= 1'b1;
						tx_data <= rxb[0];
						tx_idx <= 4'h1;
						tx_crc <= crc_byte(`MCW_CRC_INIT, rxb[0]);
					end
					else
						state <= ST_IDLE;
				end
				ST_SEND:
				begin
					if (tx_ready)
					begin
						if (tx_idx == 4'({1'b0, resp_len} + 4'h2))
						begin
							tx_valid <= 1'b0;
							state <= ST_IDLE;
						end
						else
						begin
							if (tx_idx < {1'b0, resp_len})
							begin
								tx_data <= resp[tx_idx[2:0]];
								tx_crc <= crc_byte(tx_crc, resp[tx_idx[2:0]]);
							end
							else if (tx_idx == {1'b0, resp_len})
								tx_data <= tx_crc[7:0];
							else
								tx_data <= tx_crc[15:8];
							tx_idx <= 4'(tx_idx + 4'h1);
						end
					end
				end
				default:
					state <= ST_IDLE;
			endcase
		end
	end

	logic q_eval;
	assign q_eval = state == ST_EVAL;
	sequence s_err_eval;
		q_eval && rxb[0] != `MCW_BCAST_ADDR && next_sub != `MCW_SUB_NONE;
	endsequence
	sequence s_send_start;
		state == ST_SEND && tx_data == $past(rxb[0]);
	endsequence

	chk_bcast_silent: assert property (q_eval && rxb[0] == `MCW_BCAST_ADDR |=> state == ST_IDLE)
		else $error("broadcast query started a reply");
	chk_addr_error: assert property (q_eval && q_fc == `MCW_FC_WRITE_COILS &&
		q_addr >= `MCW_COIL_LIMIT && rxb[0] != `MCW_BCAST_ADDR |=> comm_error_code == `MCW_SUB_ADDR)
		else $error("coil address 16 or above not flagged as subcode 2");
	chk_count_error: assert property (q_eval && q_fc == `MCW_FC_WRITE_COILS &&
		(q_cnt == 16'h0000 || q_cnt > `MCW_COUNT_MAX) |-> next_sub == `MCW_SUB_ADDR)
		else $error("bad coil count not flagged as subcode 2");
	chk_bc_error: assert property (q_eval && q_fc == `MCW_FC_WRITE_COILS && next_sub != `MCW_SUB_ADDR &&
		(q_bc == 8'h00 || q_bc > `MCW_BC_MAX) |-> next_sub == `MCW_SUB_DATA)
		else $error("bad byte count not flagged as subcode 3");
	chk_bc_count_pair: assert property (q_eval && q_fc == `MCW_FC_WRITE_COILS && next_sub != `MCW_SUB_ADDR &&
		q_cnt > `MCW_COUNT_ONE_BYTE && q_bc < `MCW_BC_MAX |-> next_sub == `MCW_SUB_DATA)
		else $error("count 9 or more with one data byte accepted");
	chk_small_two_bytes: assert property (q_eval && q_fc == `MCW_FC_WRITE_COILS && refuse == 6'h00 &&
		q_addr < `MCW_COIL_LIMIT && q_cnt != 16'h0000 && q_cnt <= `MCW_COUNT_ONE_BYTE &&
		q_bc == `MCW_BC_MAX |-> next_sub == `MCW_SUB_NONE)
		else $error("count 8 or less with two data bytes refused");
	chk_reserved_zero: assert property ((run_command_word & `MCW_RUN_RESERVED) == 16'h0000)
		else $error("reserved coil bit reads back as one");
	chk_first_coil: assert property (q_write && q_addr != 16'h0009 && q_addr != 16'h000a &&
		q_addr != 16'h000b |=> run_command_word[$past(q_addr[3:0])] == $past(q_data[0]))
		else $error("first written coil does not follow data bit 0");
	chk_no_exec_err: assert property (q_eval && next_sub != `MCW_SUB_NONE |=> $stable(run_command_word))
		else $error("refused query changed the run command word");
	chk_exc_byte: assert property (s_err_eval |=> resp[1] == ($past(q_fc) > `MCW_EXC_FLAG ?
		$past(q_fc) : 8'($past(q_fc) + `MCW_EXC_FLAG)) && resp[0] == $past(rxb[0]))
		else $error("exception byte or station wrong in error reply");
	chk_err_frame: assert property (s_err_eval ##1 s_send_start |-> resp_len == `MCW_LEN_ERR &&
		comm_error_code == resp[2])
		else $error("error reply length or stored subcode wrong");
	chk_echo: assert property (q_eval && q_reply && next_sub == `MCW_SUB_NONE |=>
		resp[2] == $past(rxb[2]) && resp[3] == $past(rxb[3]) && resp[4] == $past(rxb[4]) &&
		resp[5] == $past(rxb[5]) && resp_len == `MCW_LEN_ECHO)
		else $error("normal reply does not echo address and count");
	chk_gap_frame: assert property (frame_go |=> state == ST_EVAL ##1 state != ST_EVAL)
		else $error("frame end did not start exactly one evaluation");

endmodule // mcw_multi_coil_write

`default_nettype wire

// File: tb/mcw_host_model.sv
// Purpose: Host master model that sends serial queries and takes the replies.
// Assumes: Byte level link on the system clock, one rx_valid pulse per byte.
// Notes: Idle rx_data shows the inverse of the last byte, so a stale value is never trusted.
`timescale 1ns/100ps
`default_nettype none

module mcw_host_model
(
	input wire logic clock,
	input wire logic slow,
	input wire logic coin,
	output logic [7:0] rx_data,
	output logic rx_valid,
	output logic tx_ready
);
	initial
	begin
		rx_data = 8'h00;
		rx_valid = 1'b0;
	end

	// A slow host stalls at random so the hold of tx_data is exercised.
	always @(posedge clock)
		tx_ready <= !slow || coin;

	// Bytes of one frame stay well inside the silence that ends a frame.
	// A cut index inserts a long gap there to split the frame on purpose.
	task automatic send(input logic [7:0] f[$], input int cut);
		for (int i = 0; i < f.size(); i++)
		begin
			@(posedge clock);
			rx_data <= f[i];
			rx_valid <= 1'b1;
			@(posedge clock);
			rx_data <= ~f[i];
			rx_valid <= 1'b0;
			repeat (i == cut ? 80 : 2) @(posedge clock);
		end
	endtask
endmodule // mcw_host_model

`default_nettype wire

// File: tb/mcw_multi_coil_write_test.sv
// Purpose: Self-checking bench for the multiple coil write and error reply block.
// Assumes: Bit time shortened to 2 clocks, so a frame gap is 66 clocks.
// Notes: Expected replies, coil map and error code come from an integer model here.
`timescale 1ns/100ps
`default_nettype none
`include "mcw_params.svh"

module mcw_multi_coil_write_test;
	logic clock, sys_rst, avs_read, avs_write, avs_waitrequest, rx_valid, tx_valid, tx_ready;
	logic slow, coin;
	logic [4:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd, seed;
	logic [7:0] rx_data, tx_data, comm_error_code;
	logic [15:0] run_command_word;
	logic [7:0] got[$];
	int n_fail, checks_done, run, err, refuse;
	int et[7][3] = '{'{16, 1, 1}, '{0, 0, 1}, '{0, 17, 2}, '{0, 4, 0}, '{0, 4, 3}, '{0, 9, 1},
		'{1, 9, 1}};
	int rt[8] = '{1, 2, 4, 8, 16, 'h18, 'h38, 'h30};

	mcw_multi_coil_write i_mcw_multi_coil_write (.clock(clock), .sys_rst(sys_rst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .rx_data(rx_data), .rx_valid(rx_valid),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.run_command_word(run_command_word), .comm_error_code(comm_error_code));
	mcw_host_model i_mcw_host_model (.clock(clock), .slow(slow), .coin(coin),
		.rx_data(rx_data), .rx_valid(rx_valid), .tx_ready(tx_ready));

	initial
	begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	always @(posedge clock)
		coin <= ^xs();

	always @(posedge clock)
		if (tx_valid === 1'b1 && tx_ready === 1'b1)
			got.push_back(tx_data);

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] a, input logic [31:0] e);
		checks_done++;
		if (a !== e)
		begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, a, e);
		end
	endtask

	function automatic logic [15:0] crc16(input logic [7:0] f[$]);
		logic [15:0] c;
		c = 16'hffff;
		foreach (f[i])
		begin
			c ^= {8'h00, f[i]};
			for (int k = 0; k < 8; k++)
				c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
		end
		return c;
	endfunction

	// The request is held until waitrequest is seen low at a rising edge.
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clock);
		avs_read <= !wr;
		avs_write <= wr;
		avs_address <= a;
		avs_writedata <= d;
		do
		begin
			@(posedge clock);
			k++;
		end
		while (avs_waitrequest !== 1'b0 && k < 50);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (k >= 50)
		begin
			n_fail++;
			wrap_up();
		end
	endtask

	task automatic rchk(input logic [4:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		check(rd, e);
	endtask

	// Mode 0 sends a clean frame, 1 spoils the last check byte, 2 splits the frame.
	task automatic query(input int st, input int fc, input int ad, input int cn, input int bc,
		input int dat, input int mode);
		logic [7:0] f[$];
		logic [7:0] e[$];
		logic [15:0] c;
		int sub;
		f = {st[7:0], fc[7:0], ad[15:8], ad[7:0], cn[15:8], cn[7:0], bc[7:0]};
		for (int i = 0; i < bc; i++)
			f.push_back(8'(dat >> (8 * i)));
		c = crc16(f);
		f.push_back(c[7:0]);
		f.push_back(c[15:8]);
		if (mode == 1)
			f[f.size() - 1] ^= 8'h01;
		sub = 0;
		if (!(fc inside {1, 3, 5, 6, 8, 15, 16}))
			sub = 1;
		else if ((fc == 15 && (ad >= 16 || cn == 0 || cn > 16)) || refuse[2:0] != 0)
			sub = 2;
		else if (fc == 15 && (bc == 0 || bc >= 3 || (cn >= 9 && bc <= 1)))
			sub = 3;
		else if (refuse[4] && (refuse[5] || !refuse[3]))
			sub = 7;
		else if (refuse[3])
			sub = 3;
		if (mode == 0 && (st == 1 || st == 0))
		begin
			if (sub == 0 && fc == 15)
				for (int i = 0; i < cn; i++)
					if (ad + i < 16)
						run[ad + i] = dat[i];
			run = run & 'hf1ff;
			if (st != 0 && sub != 0)
			begin
				err = sub;
				e = {st[7:0], fc > 'h80 ? fc[7:0] : 8'(fc + 'h80), 8'(sub)};
			end
			else if (st != 0 && fc == 15)
				e = {f[0], f[1], f[2], f[3], f[4], f[5]};
			if (e.size() > 0)
			begin
				c = crc16(e);
				e.push_back(c[7:0]);
				e.push_back(c[15:8]);
			end
		end
		got.delete();
		i_mcw_host_model.send(f, mode == 2 ? 2 : -1);
		repeat (200) @(posedge clock);
		check(got.size(), e.size());
		foreach (e[i])
			if (i < got.size())
				check(got[i], e[i]);
		check(run_command_word, run);
		check(comm_error_code, err);
	endtask

	initial
	begin
		repeat (40000) @(posedge clock);
		n_fail++;
		wrap_up();
	end

	initial
	begin
		{n_fail, checks_done, run, err, refuse} = '0;
		seed = 32'h0910de76;
		{sys_rst, avs_read, avs_write, avs_address, avs_writedata, slow} = '0;
		sys_rst = 1'b1;
		repeat (16) @(posedge clock);
		sys_rst <= 1'b0;
		rchk(`MCW_REG_STATION, 32'h1);
		rchk(`MCW_REG_BIT_CYCLES, 32'h32dd);
		bus(1'b1, 5'h1c, 32'hffffffff);
		rchk(5'h1c, 32'h0);
		bus(1'b1, `MCW_REG_RUN_CMD, 32'hffff);
		rchk(`MCW_REG_RUN_CMD, 32'h0);
		bus(1'b1, `MCW_REG_BIT_CYCLES, 32'h2);
		rchk(`MCW_REG_BIT_CYCLES, 32'h2);
		repeat (100) @(posedge clock);
		$display("test registers done");
		for (int i = 0; i < 4; i++)
		begin
			slow <= i[0];
			query(1, 15, 0, 16, 2, xs(), 0);
		end
		query(1, 15, 2, 9, 2, 'hffff, 0);
		query(1, 15, 15, 16, 2, 'h0000, 0);
		query(1, 15, 0, 8, 2, 'hff5a, 0);
		query(1, 15, 0, 8, 1, 'h00a5, 0);
		rchk(`MCW_REG_STATUS, 32'h0);
		$display("test good writes done");
		foreach (et[i])
			query(1, 15, et[i][0], et[i][1], et[i][2], xs(), 0);
		rchk(`MCW_REG_STATUS, 32'h2);
		rchk(`MCW_REG_COMM_ERR, err);
		query(1, 2, 0, 4, 1, xs(), 0);
		query(1, 'h85, 0, 4, 1, xs(), 0);
		query(1, 3, 20, 0, 0, xs(), 0);
		$display("test error replies done");
		query(0, 15, 0, 16, 2, xs(), 0);
		query(0, 15, 16, 1, 1, xs(), 0);
		query(7, 15, 0, 16, 2, xs(), 0);
		query(1, 15, 0, 16, 2, xs(), 1);
		query(1, 15, 0, 16, 2, xs(), 2);
		$display("test framing done");
		foreach (rt[i])
		begin
			refuse = rt[i];
			bus(1'b1, `MCW_REG_REFUSE, 32'(refuse));
			query(1, 15, 0, 4, 1, xs(), 0);
			query(1, 2, 0, 4, 1, xs(), 0);
		end
		refuse = 0;
		bus(1'b1, `MCW_REG_REFUSE, 32'h0);
		query(1, 15, 3, 5, 1, xs(), 0);
		$display("test refusals done");
		wrap_up();
	end
endmodule // mcw_multi_coil_write_test

`default_nettype wire
